// ---- gfc_device.sv ----
// Overview of operation
// - divide 10 MHz reference by five
// - timebase muxed into channel two gate
// - resolution setting in decades 10 Hz-1 MHz
// - gate 200 ms, 20 ms, else 2 ms
// - input edges pass only during gate
// - two four-bit stages form eight-bit prescaler
// - prescaler msb clocks timer channel zero
// - channel zero overflow sets overflow flag
// - gate end sets done flag while ack high
// - prescaler read strobe drives prescaler bits
// - select plus read drives timer count
// - ack low clears done flag
// - measured input nominally 5.35 MHz
module gfc_device #(
   parameter int unsigned TIMER_W = 16
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic ref_clk_in,
   input wire logic alt_clk_in,
   input wire logic measured_input_in,
   gfc_link_if.device link
);
   import gfc_pkg::*;
   // timer width limits: below 8 the readback packing breaks,
   // above 16 the shared bus cannot carry the count in one word
   if (TIMER_W < 8 || TIMER_W > 16) begin : g_bad_width
      $error("timer width out of range");
   end
   // general notes for whoever touches this block next:
   // - every pin is sampled by the system clock, so the reference,
   //   the alternate source and the measured input must each stay
   //   well below half the system rate
   // - all counting happens on enable pulses, never on derived clocks,
   //   so the whole block stays in one timing domain
   // - the gate, the prescaler and the timer restart together at
   //   each start; a start while the gate is open is ignored
   // pin synchronisers, two flops each
   // third flop only remembers the previous settled level,
   // so edge detection never reads a metastable first stage
   // reset value matches the idle low level of every pin,
   // so no false edge follows reset
   logic [2:0] s1_q, s2_q, s3_q;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end else begin
         s1_q <= {measured_input_in, alt_clk_in, ref_clk_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   wire ref_rise = s2_q[0] & ~s3_q[0];
   wire alt_rise = s2_q[1] & ~s3_q[1];
   wire meas_rise = s2_q[2] & ~s3_q[2];
   // reference divide by five into timebase enable
   // wrap pulse lasts one system cycle and is the timebase tick
   // divider restarts only on reset; ticks keep running between gates
   logic [2:0] div_q;
   wire div_wrap = ref_rise && (div_q == 3'(GFC_REF_DIV - 1));
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) div_q <= 3'h0;
      else if (ref_rise) div_q <= div_wrap ? 3'h0 : div_q + 3'h1;
   end
   // source mux: timebase in count mode, alternate otherwise
   wire timer_ch2_clock = link.fc_mode ? div_wrap : alt_rise;
   // gate length from resolution; coarse settings share 2 ms
   logic [18:0] gate_len;
   always_comb begin
      case (link.resolution)
         GFC_RES_10HZ: gate_len = 19'(GFC_GATE_TICKS_10HZ);
         GFC_RES_100HZ: gate_len = 19'(GFC_GATE_TICKS_100HZ);
         default: gate_len = 19'(GFC_GATE_TICKS_COARSE);
      endcase
   end
   // channel two one-shot: gate high for gate_len timebase ticks
   typedef enum logic [1:0] {
      GFC_G_IDLE = 2'b01,
      GFC_G_OPEN = 2'b10
   } gfc_gate_t;
   gfc_gate_t g_q, g_d;
   logic [18:0] gcnt_q;
   logic gate_q;
   wire gate_last = timer_ch2_clock && (gcnt_q == 19'h1);
   // next state: start opens, last timebase tick closes
   always_comb begin
      case (g_q)
         GFC_G_IDLE: g_d = link.start ? GFC_G_OPEN : GFC_G_IDLE;
         GFC_G_OPEN: g_d = gate_last ? GFC_G_IDLE : GFC_G_OPEN;
         default: g_d = GFC_G_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) g_q <= GFC_G_IDLE;
      else g_q <= g_d;
   end
   // tick counter loaded at open; gate length is fixed at that moment
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) gcnt_q <= 19'h0;
      else if (link.start && !gate_q) gcnt_q <= gate_len;
      else if (gate_q && timer_ch2_clock) gcnt_q <= gcnt_q - 19'h1;
   end
   assign gate_q = (g_q == GFC_G_OPEN);
   assign link.gate_pulse = gate_q;
   // gated input; counters cleared at each gate start
   wire gated_edge = meas_rise & gate_q;
   wire gate_start = link.start & ~gate_q;
   logic [7:0] presc_q;
   logic [TIMER_W-1:0] t0_q;
   logic t0_out_q;
   wire timer_ch0_clock = gated_edge && (presc_q == 8'hff); // msb falls
   // two cascaded four-bit stages; upper steps when the lower is full
   logic [3:0] nib_q [2];
   logic [1:0] nib_en;
   assign nib_en[0] = gated_edge;
   assign nib_en[1] = gated_edge & (nib_q[0] == 4'hf);
   for (genvar g = 0; g < 2; g++) begin : g_nib
      always_ff @(posedge clk_sys_in) begin
         if (sys_rst_in || gate_start) nib_q[g] <= 4'h0;
         else if (nib_en[g]) nib_q[g] <= nib_q[g] + 4'h1;
      end
   end
   // all eight stage bits stay visible for readback
   assign presc_q = {nib_q[1], nib_q[0]};
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || gate_start) begin
         t0_q <= '0;
         t0_out_q <= 1'b0;
      end else if (timer_ch0_clock) begin
         t0_q <= t0_q + 1'b1;
         if (&t0_q) t0_out_q <= 1'b1;
      end
   end
   // flags: overflow sticky until next gate; done follows gate fall
   logic ovf_q, done_q, gate_d1_q;
   wire gate_fall = gate_d1_q & ~gate_q;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ovf_q <= 1'b0;
         done_q <= 1'b0;
         gate_d1_q <= 1'b0;
      end else begin
         gate_d1_q <= gate_q;
         // start also clears the timer output, but only one cycle later, so the two can be high together;
         // without start first, the still-high output would re-set the flag at the start edge and keep it set through the new gate
         if (gate_start) ovf_q <= 1'b0;
         else if (t0_out_q) ovf_q <= 1'b1;
         if (!link.count_irq_ack) done_q <= 1'b0; // clear held while ack low
         else if (gate_fall) done_q <= 1'b1;
      end
   end
   assign link.overflow_irq = ovf_q;
   assign link.count_done_irq = done_q;
   // read-back onto the shared bus, registered
   // data and enable lag the strobe by one cycle; the host must
   // hold its strobe at least two cycles and sample in the second
   // prescaler read wins if both strobes are low at once
   // bus word is zero whenever nothing is driven, matching the
   // pull-down level that the host sees on a released bus
   wire rd_presc = ~link.prescaler_read_n;
   wire rd_timer = ~link.timer_select_n & ~link.timer_read_n;
   logic [15:0] bus_q;
   logic oe_q;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         bus_q <= 16'h0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= rd_presc | rd_timer;
         bus_q <= rd_presc ? {8'h0, presc_q} : (rd_timer ? 16'(t0_q) : 16'h0);
      end
   end
   assign link.dev_bus_data = bus_q;
   assign link.dev_bus_oe = oe_q;
endmodule : gfc_device

// ---- gfc_pkg.sv ----
package gfc_pkg;
   // clocking
   localparam int unsigned GFC_CLK_HZ = 40_000_000;
   localparam int unsigned GFC_REF_DIV = 5;
   localparam int unsigned GFC_TB_HZ = 2_000_000;
   // gate times in microseconds, counted in timebase ticks
   localparam int unsigned GFC_GATE_US_10HZ = 200_000;
   localparam int unsigned GFC_GATE_US_100HZ = 20_000;
   localparam int unsigned GFC_GATE_US_COARSE = 2_000;
   localparam int unsigned GFC_GATE_TICKS_10HZ = GFC_GATE_US_10HZ * (GFC_TB_HZ / 1_000_000);
   localparam int unsigned GFC_GATE_TICKS_100HZ = GFC_GATE_US_100HZ * (GFC_TB_HZ / 1_000_000);
   localparam int unsigned GFC_GATE_TICKS_COARSE = GFC_GATE_US_COARSE * (GFC_TB_HZ / 1_000_000);
   // resolution codes, decade steps
   typedef enum logic [2:0] {
      GFC_RES_10HZ = 3'h0,
      GFC_RES_100HZ = 3'h1,
      GFC_RES_1KHZ = 3'h2,
      GFC_RES_10KHZ = 3'h3,
      GFC_RES_100KHZ = 3'h4,
      GFC_RES_1MHZ = 3'h5
   } gfc_res_t;
   // host register map
   localparam logic [3:0] GFC_REG_CTRL = 4'h0;
   localparam logic [3:0] GFC_REG_STATUS = 4'h1;
   localparam logic [3:0] GFC_REG_MASK = 4'h2;
   localparam logic [3:0] GFC_REG_PRESC = 4'h3;
   localparam logic [3:0] GFC_REG_TIMER = 4'h4;
   // ctrl fields
   localparam int unsigned GFC_CTRL_START = 0;
   localparam int unsigned GFC_CTRL_FCMODE = 1;
   localparam int unsigned GFC_CTRL_ACK = 2;
   localparam int unsigned GFC_CTRL_ALT = 3;
   localparam int unsigned GFC_CTRL_RES_LO = 4;
   // status/mask fields
   localparam int unsigned GFC_ST_DONE = 0;
   localparam int unsigned GFC_ST_OVF = 1;
   localparam int unsigned GFC_ST_FETCHED = 2;
   localparam logic [7:0] GFC_CTRL_RESET = 8'h02;
endpackage : gfc_pkg

// ---- gfc_link_if.sv ----
interface gfc_link_if;
   logic gate_pulse;
   logic overflow_irq;
   logic count_done_irq;
   logic count_irq_ack;
   logic prescaler_read_n;
   logic timer_select_n;
   logic timer_read_n;
   logic [15:0] dev_bus_data;
   logic dev_bus_oe;
   logic fc_mode;
   logic alt_sel;
   logic [2:0] resolution;
   logic start;
   // shared data bus level as seen by the host
   wire [15:0] shared_data_bus = dev_bus_oe ? dev_bus_data : 16'h0000;
   modport device (
      output gate_pulse, overflow_irq, count_done_irq, dev_bus_data, dev_bus_oe,
      input count_irq_ack, prescaler_read_n, timer_select_n, timer_read_n,
      input fc_mode, alt_sel, resolution, start
   );
   modport host (
      input gate_pulse, overflow_irq, count_done_irq, shared_data_bus,
      output count_irq_ack, prescaler_read_n, timer_select_n, timer_read_n,
      output fc_mode, alt_sel, resolution, start
   );
endinterface : gfc_link_if

// ---- gfc_host.sv ----
module gfc_host (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   output logic irq_out,
   gfc_link_if.host link
);
   import gfc_pkg::*;
   logic [7:0] ctrl_q;
   logic [2:0] st_q, mask_q;
   logic [7:0] presc_cap_q;
   logic [15:0] timer_cap_q, rdata_q;
   logic start_q;
   // fetch sequencer after count done
   typedef enum logic [3:0] {
      GFC_F_IDLE = 4'b0001, GFC_F_PRESC = 4'b0010, GFC_F_TIMER = 4'b0100, GFC_F_ACK = 4'b1000
   } gfc_fetch_t;
   gfc_fetch_t f_q, f_d;
   logic [1:0] fw_q;
   wire done_rise = link.count_done_irq && f_q == GFC_F_IDLE;
   always_comb begin
      case (f_q)
         GFC_F_IDLE: f_d = done_rise ? GFC_F_PRESC : GFC_F_IDLE;
         GFC_F_PRESC: f_d = (fw_q == 2'h2) ? GFC_F_TIMER : GFC_F_PRESC;
         GFC_F_TIMER: f_d = (fw_q == 2'h2) ? GFC_F_ACK : GFC_F_TIMER;
         GFC_F_ACK: f_d = link.count_done_irq ? GFC_F_ACK : GFC_F_IDLE;
         default: f_d = GFC_F_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || f_d != f_q) fw_q <= 2'h0;
      else if (fw_q != 2'h3) fw_q <= fw_q + 2'h1;
   end
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) f_q <= GFC_F_IDLE;
      else f_q <= f_d;
   end
   // strobes and ack from state
   assign link.prescaler_read_n = ~(f_q == GFC_F_PRESC);
   assign link.timer_select_n = ~(f_q == GFC_F_TIMER);
   assign link.timer_read_n = ~(f_q == GFC_F_TIMER);
   assign link.count_irq_ack = ctrl_q[GFC_CTRL_ACK] & (f_q != GFC_F_ACK);
   assign link.fc_mode = ctrl_q[GFC_CTRL_FCMODE];
   assign link.alt_sel = ctrl_q[GFC_CTRL_ALT];
   assign link.resolution = ctrl_q[GFC_CTRL_RES_LO +: 3];
   assign link.start = start_q;
   // register port decode
   wire wr_ctrl = wr_in && addr_in == GFC_REG_CTRL;
   wire wr_st = wr_in && addr_in == GFC_REG_STATUS;
   wire wr_mask = wr_in && addr_in == GFC_REG_MASK;
   wire fetched = f_q == GFC_F_ACK && !link.count_done_irq;
   wire [2:0] ev = {fetched, link.overflow_irq, 1'b0};
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ctrl_q <= GFC_CTRL_RESET;
         mask_q <= 3'h0;
         start_q <= 1'b0;
      end else begin
         start_q <= wr_ctrl & wdata_in[GFC_CTRL_START];
         if (wr_ctrl) ctrl_q <= {wdata_in[7:1], 1'b0};
         if (wr_mask) mask_q <= wdata_in[2:0];
      end
   end
   // sticky status: set wins over write-one clear
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) st_q <= 3'h0;
      else st_q <= (st_q & ~(wr_st ? wdata_in[2:0] : 3'h0)) | ev | {2'h0, done_rise};
   end
   // capture bus words one cycle after strobe
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         presc_cap_q <= 8'h0;
         timer_cap_q <= 16'h0;
      end else if (fw_q == 2'h1 && f_q == GFC_F_PRESC) presc_cap_q <= link.shared_data_bus[7:0];
      else if (fw_q == 2'h1 && f_q == GFC_F_TIMER) timer_cap_q <= link.shared_data_bus;
   end
   wire [15:0] rd_mux = addr_in == GFC_REG_CTRL ? {8'h0, ctrl_q} :
      addr_in == GFC_REG_STATUS ? {13'h0, st_q} :
      addr_in == GFC_REG_MASK ? {13'h0, mask_q} :
      addr_in == GFC_REG_PRESC ? {8'h0, presc_cap_q} :
      addr_in == GFC_REG_TIMER ? timer_cap_q : 16'h0;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) rdata_q <= 16'h0;
      else if (rd_in) rdata_q <= rd_mux;
      else rdata_q <= 16'h0;
   end
   assign rdata_out = rdata_q;
   assign irq_out = |(st_q & mask_q);
endmodule : gfc_host

// ---- gfc_monitor.sv ----
module gfc_monitor (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic gate_pulse,
   input wire logic overflow_irq,
   input wire logic count_done_irq,
   input wire logic count_irq_ack,
   input wire logic prescaler_read_n,
   input wire logic timer_select_n,
   input wire logic timer_read_n,
   input wire logic dev_bus_oe,
   input wire logic start
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   // strobe states on the link; the bus enable is registered, so it lags one cycle
   sequence s_timer_rd; !timer_select_n && !timer_read_n; endsequence
   sequence s_no_rd; prescaler_read_n && (timer_select_n || timer_read_n); endsequence
   sequence s_ack_low; !count_irq_ack; endsequence
   a_presc_drive: assert property ($fell(prescaler_read_n) |-> ##[1:2] dev_bus_oe)
      else $error("prescaler read left the bus undriven");
   a_timer_drive: assert property (s_timer_rd ##1 s_timer_rd |-> dev_bus_oe)
      else $error("timer read left the bus undriven");
   a_bus_release: assert property (s_no_rd ##1 s_no_rd |-> !dev_bus_oe)
      else $error("bus driven without a read strobe");
   a_gate_open: assert property (start && !gate_pulse |=> gate_pulse)
      else $error("start did not open the gate");
   a_gate_cause: assert property ($rose(gate_pulse) |-> $past(start))
      else $error("gate opened without start");
   a_done_after_gate: assert property ($rose(count_done_irq) |->
      $past(gate_pulse, 2) && !$past(gate_pulse) && $past(count_irq_ack))
      else $error("done flag set without gate end and ack");
   a_ack_clears: assert property (s_ack_low ##1 s_ack_low |-> !count_done_irq)
      else $error("done flag held while ack low");
   a_ovf_hold: assert property ($fell(overflow_irq) |-> $past(start))
      else $error("overflow flag dropped without start");
endmodule : gfc_monitor

// ---- test_gated_frequency_counter.sv ----
module test_gated_frequency_counter;
   timeunit 1ns;
   timeprecision 1ps;
   import gfc_pkg::*;
   // reference toggles every cycle, so one timebase tick is ten system cycles
   localparam int GATE_CYC = GFC_GATE_TICKS_COARSE * GFC_REF_DIV * 2;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic ref_clk_in = 1'b0;
   logic alt_clk_in = 1'b0;
   logic measured_input_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [15:0] rdata_out;
   logic irq_out;
   logic [15:0] rd_val;
   logic meas_q = 1'b0;
   int failures = 0;
   int num_checks = 0;
   int edges = 0;
   int gate_len = 0;
   int meas_cnt = 0;
   int gate_cnt;
   int edge_cnt;
   int total;
   gfc_link_if link_if ();
   gfc_device u_gfc_device (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .ref_clk_in(ref_clk_in), .alt_clk_in(alt_clk_in),
      .measured_input_in(measured_input_in), .link(link_if));
   gfc_host u_gfc_host (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .irq_out(irq_out), .link(link_if));
   gfc_monitor u_gfc_monitor (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .gate_pulse(link_if.gate_pulse), .overflow_irq(link_if.overflow_irq),
      .count_done_irq(link_if.count_done_irq), .count_irq_ack(link_if.count_irq_ack),
      .prescaler_read_n(link_if.prescaler_read_n), .timer_select_n(link_if.timer_select_n),
      .timer_read_n(link_if.timer_read_n), .dev_bus_oe(link_if.dev_bus_oe),
      .start(link_if.start));
   always #12.5 clk_sys_in = ~clk_sys_in;
   // stimulus pins and a reference count of gated input rises
   always @(posedge clk_sys_in) begin
      ref_clk_in <= ~ref_clk_in;
      alt_clk_in <= ref_clk_in;
      meas_cnt <= (meas_cnt == 2) ? 0 : meas_cnt + 1;
      if (meas_cnt == 2) measured_input_in <= ~measured_input_in;
      meas_q <= measured_input_in;
      if (link_if.gate_pulse === 1'b1) gate_len <= gate_len + 1;
      if (link_if.gate_pulse === 1'b1 && measured_input_in && !meas_q) edges <= edges + 1;
   end
   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : reg_rd
   // bounded wait; a hung gate ends the run as a failure
   task automatic wait_gate(input logic lvl);
      int n;
      n = 0;
      while (link_if.gate_pulse !== lvl && n < 50000) begin
         @(posedge clk_sys_in);
         n++;
      end
      if (n >= 50000) begin
         chk(1'b0, "gate wait timed out");
         print_verdict();
      end
   endtask : wait_gate
   task automatic run_gate(input logic [15:0] ctrl);
      int g0;
      int e0;
      reg_wr(GFC_REG_CTRL, ctrl);
      wait_gate(1'b1);
      g0 = gate_len;
      e0 = edges;
      wait_gate(1'b0);
      #1 gate_cnt = gate_len - g0;
      edge_cnt = edges - e0;
      chk(gate_cnt >= GATE_CYC - 4 && gate_cnt <= GATE_CYC + 4, "gate length");
   endtask : run_gate
   initial begin
      repeat (3) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      reg_rd(GFC_REG_CTRL, rd_val);
      chk(rd_val === {8'h00, GFC_CTRL_RESET}, "ctrl reset value");
      reg_rd(4'hF, rd_val);
      chk(rd_val === 16'h0000, "unmapped read");
      for (int r = 0; r < 6; r++) begin
         reg_wr(GFC_REG_CTRL, 16'(r << 4) | 16'h0002);
         reg_rd(GFC_REG_CTRL, rd_val);
         chk(rd_val[6:4] === r[2:0], "resolution readback");
      end
      // coarsest setting with ack low: no done flag may appear
      run_gate(16'h0053);
      repeat (4) @(posedge clk_sys_in);
      chk(link_if.count_done_irq === 1'b0, "done without ack");
      reg_wr(GFC_REG_MASK, 16'h0001);
      run_gate(16'h0027);
      repeat (40) @(posedge clk_sys_in);
      chk(irq_out === 1'b1, "irq after done");
      reg_rd(GFC_REG_STATUS, rd_val);
      chk((rd_val & 16'h0007) === 16'h0005, "status after fetch");
      chk(link_if.overflow_irq === 1'b0, "no overflow");
      reg_rd(GFC_REG_PRESC, rd_val);
      total = int'(rd_val[7:0]);
      reg_rd(GFC_REG_TIMER, rd_val);
      total += int'(rd_val) * 256;
      chk(total >= edge_cnt - 3 && total <= edge_cnt + 3, "gated edge count");
      chk(link_if.count_done_irq === 1'b0, "done cleared");
      reg_wr(GFC_REG_MASK, 16'h0000);
      repeat (2) @(posedge clk_sys_in);
      chk(irq_out === 1'b0, "masked irq");
      reg_wr(GFC_REG_MASK, 16'h0001);
      reg_wr(GFC_REG_STATUS, 16'h0007);
      reg_rd(GFC_REG_STATUS, rd_val);
      chk((rd_val & 16'h0007) === 16'h0000, "status cleared");
      chk(irq_out === 1'b0, "irq after clear");
      print_verdict();
   end
endmodule : test_gated_frequency_counter
